// ==== hdl/cal_alarm_pkg.sv ====
// constants for the month, year and alarm match block
package cal_alarm_pkg;
  // register offsets
  localparam logic [5:0] OFS_MONTH = 6'h0D;
  localparam logic [5:0] OFS_YEAR = 6'h0E;
  localparam logic [5:0] OFS_ALM_SEC = 6'h10;
  localparam logic [5:0] OFS_ALM_MIN = 6'h11;
  // implemented bit masks, unused positions read zero
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'h7F;
  localparam logic [7:0] MASK_ALARM = 8'hFF;
  // field positions
  localparam int MATCH_EN_BIT = 7;
  // reset values
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_ALARM = 8'h00;
  // counting limits in bcd
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_FIRST = 8'h00;
  localparam logic [7:0] YEAR_LAST = 8'h79;
  localparam logic [7:0] FEBRUARY = 8'h02;
endpackage : cal_alarm_pkg

// ==== hdl/cal_alarm.sv ====
// month and year counters with second and minute alarm match
`timescale 1ns/1ps
`default_nettype none

module cal_alarm
(
  input wire logic i_core_clk, // 100 MHz core clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  input wire logic [5:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // write data
  output logic [7:0] o_reg_rdata, // read data, valid cycle after i_reg_rd
  input wire logic i_tick, // pulse: time counters just updated
  input wire logic i_month_carry, // pulse: day counter rolled over
  input wire logic [6:0] i_second, // current bcd seconds
  input wire logic [6:0] i_minute, // current bcd minutes
  input wire logic i_alarm_irq_enable, // interrupt control enable bit
  input wire logic i_flag_clear, // pulse: software clears alarm flag
  output logic o_alarm_hit_flag, // alarm flag
  output logic o_alarm_irq, // interrupt output, active high
  output logic [7:0] o_month, // current month to day counter
  output logic [7:0] o_year, // current year
  output logic o_feb_has_29 // february has a 29th day
);
  import cal_alarm_pkg::*;

  // ****************************************
  // functions
  // ****************************************

  // bcd increment of a two digit value with wrap
  function automatic logic [7:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last,
                                          input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v == last)
      r = first;
    else if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, 4'h0};
    else
      r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_step

  // bcd year divisible by four
  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (y[4] == 1'b0)
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    else
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    return r;
  endfunction : is_leap

  // ****************************************
  // registers
  // ****************************************

  logic [7:0] alarm_second_match;
  logic [7:0] alarm_minute_match;
  logic prev_match;
  logic cur_match;
  logic any_enable;
  logic second_match_enable;
  logic minute_match_enable;
  logic wr_month;
  logic wr_year;
  logic next_flag;

  assign wr_month = i_reg_wr && (i_reg_addr == OFS_MONTH);
  assign wr_year = i_reg_wr && (i_reg_addr == OFS_YEAR);
  assign second_match_enable = alarm_second_match[MATCH_EN_BIT];
  assign minute_match_enable = alarm_minute_match[MATCH_EN_BIT];

  // month counter, a write wins over the carry
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_month <= RST_MONTH;
    else if (wr_month)
      o_month <= i_reg_wdata & MASK_MONTH;
    else if (i_month_carry)
      o_month <= bcd_step(o_month, MONTH_LAST, MONTH_FIRST);
  end

  // year counter, steps when december rolls over
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_year <= RST_YEAR;
    else if (wr_year)
      o_year <= i_reg_wdata & MASK_YEAR;
    else if (i_month_carry && (o_month == MONTH_LAST))
      o_year <= bcd_step(o_year, YEAR_LAST, YEAR_FIRST);
  end

  // leap year indication for the day counter
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_feb_has_29 <= 1'b0;
    else
      o_feb_has_29 <= is_leap(o_year);
  end

  // alarm match registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      alarm_second_match <= RST_ALARM;
      alarm_minute_match <= RST_ALARM;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == OFS_ALM_SEC)
        alarm_second_match <= i_reg_wdata & MASK_ALARM;
      if (i_reg_addr == OFS_ALM_MIN)
        alarm_minute_match <= i_reg_wdata & MASK_ALARM;
    end
  end

  // read port, unmapped offsets read zero
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        OFS_MONTH: o_reg_rdata <= o_month & MASK_MONTH;
        OFS_YEAR: o_reg_rdata <= o_year & MASK_YEAR;
        OFS_ALM_SEC: o_reg_rdata <= alarm_second_match;
        OFS_ALM_MIN: o_reg_rdata <= alarm_minute_match;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // alarm compare
  // ****************************************

  // disabled fields pass, no enabled field means no match
  always_comb
  begin
    any_enable = second_match_enable || minute_match_enable;
    cur_match = any_enable
      && (!second_match_enable
          || (i_second == alarm_second_match[6:0]))
      && (!minute_match_enable
          || (i_minute == alarm_minute_match[6:0]));
  end

  // match state sampled once per counter update
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      prev_match <= 1'b0;
    else if (i_tick)
      prev_match <= cur_match;
  end

  // flag: a set in the same cycle as a clear wins
  always_comb
  begin
    next_flag = o_alarm_hit_flag;
    if (i_flag_clear)
      next_flag = 1'b0;
    if (i_tick && cur_match && !prev_match && i_alarm_irq_enable)
      next_flag = 1'b1;
  end

  // flag and interrupt output
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_alarm_hit_flag <= 1'b0;
      o_alarm_irq <= 1'b0;
    end
    else
    begin
      o_alarm_hit_flag <= next_flag;
      o_alarm_irq <= next_flag;
    end
  end

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_month_wrap;
    (i_month_carry && !wr_month && o_month == MONTH_LAST)
      |=> (o_month == MONTH_FIRST);
  endproperty
  a_month_wrap: assert property (p_month_wrap)
    else $error("month did not wrap to january");

  property p_year_wrap;
    (i_month_carry && o_month == MONTH_LAST && !wr_year
      && o_year == YEAR_LAST) |=> (o_year == YEAR_FIRST);
  endproperty
  a_year_wrap: assert property (p_year_wrap)
    else $error("year did not wrap to zero");

  property p_leap;
    (o_year == 8'h00 || o_year == 8'h24) ##1 (o_year == $past(o_year))
      |=> o_feb_has_29;
  endproperty
  a_leap: assert property (p_leap)
    else $error("leap year not flagged");

  property p_no_leap;
    (o_year == 8'h23 || o_year == 8'h79) ##1 (o_year == $past(o_year))
      |=> !o_feb_has_29;
  endproperty
  a_no_leap: assert property (p_no_leap)
    else $error("non leap year flagged");

  property p_flag_set;
    (i_tick && cur_match && !prev_match && i_alarm_irq_enable)
      |=> o_alarm_hit_flag ##0 o_alarm_irq;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("first match did not set the alarm flag");

  property p_held_match;
    (i_tick && prev_match && !o_alarm_hit_flag) |=> !o_alarm_hit_flag;
  endproperty
  a_held_match: assert property (p_held_match)
    else $error("persisting match set the flag again");

  property p_irq_follows;
    o_alarm_irq == o_alarm_hit_flag;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt output differs from alarm flag");

  property p_none_enabled;
    (!second_match_enable && !minute_match_enable && !o_alarm_hit_flag)
      |=> !o_alarm_hit_flag;
  endproperty
  a_none_enabled: assert property (p_none_enabled)
    else $error("flag set with no alarm field enabled");

  property p_second_gate;
    (i_tick && second_match_enable
      && i_second != alarm_second_match[6:0] && !o_alarm_hit_flag)
      |=> !o_alarm_hit_flag;
  endproperty
  a_second_gate: assert property (p_second_gate)
    else $error("flag set while enabled second field mismatched");

  property p_month_readback;
    (i_reg_rd && i_reg_addr == OFS_MONTH) |=> (o_reg_rdata[7:5] == 3'h0)
      && (o_reg_rdata[4:0] == $past(o_month[4:0]));
  endproperty
  a_month_readback: assert property (p_month_readback)
    else $error("month read back wrong or unused bits set");

  property p_sec_store;
    (i_reg_wr && i_reg_addr == OFS_ALM_SEC)
      |=> (alarm_second_match == $past(i_reg_wdata));
  endproperty
  a_sec_store: assert property (p_sec_store)
    else $error("second alarm register not written");

  property p_min_store;
    (i_reg_wr && i_reg_addr == OFS_ALM_MIN)
      |=> (alarm_minute_match == $past(i_reg_wdata));
  endproperty
  a_min_store: assert property (p_min_store)
    else $error("minute alarm register not written");

  // main scenarios
  c_alarm_fires: cover property (i_tick && cur_match ##1 o_alarm_irq);
  c_year_rolls: cover property (o_year == YEAR_LAST ##1 o_year == YEAR_FIRST);
  c_set_and_clear: cover property (i_flag_clear && next_flag);
  c_feb_leap: cover property (o_month == FEBRUARY && o_feb_has_29);

endmodule : cal_alarm

`default_nettype wire

// ==== tb/cal_host.sv ====
// host model: register strobe port standing in for the serial host link
`timescale 1ns/1ps
`default_nettype none

module cal_host
(
  input wire logic i_clk, // core clock
  output logic o_wr, // write strobe
  output logic o_rd, // read strobe
  output logic [5:0] o_addr, // register offset
  output logic [7:0] o_wdata, // write data
  input wire logic [7:0] i_rdata // read data
);
  // ****
  // idle port at time zero
  // ****
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end

  // one write, strobe held across exactly one sampling edge
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d; // data is passed as given, out-of-range values included
    @(posedge i_clk);
    o_wr <= 1'b0;
    #1;
  endtask : put

  // one read, data taken the cycle after the read edge
  task automatic get(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : get
endmodule : cal_host

`default_nettype wire

// ==== tb/cal_alarm_tb.sv ====
// self-checking bench for the month, year and alarm match block
`timescale 1ns/1ps
`default_nettype none

module cal_alarm_tb;
  import cal_alarm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, flag, irq, feb29;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, month, year, rv;
  logic tick = 1'b0;
  logic carry = 1'b0;
  logic irq_en = 1'b0;
  logic clr = 1'b0;
  logic [6:0] sec = 7'h00;
  logic [6:0] min = 7'h00;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] yrs [8] = '{8'h00, 8'h04, 8'h12, 8'h20, 8'h23, 8'h36, 8'h79,
    8'h58};
  logic lp [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #5 clk = ~clk;

  cal_alarm u_cal_alarm (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_tick(tick), .i_month_carry(carry),
    .i_second(sec), .i_minute(min), .i_alarm_irq_enable(irq_en),
    .i_flag_clear(clr), .o_alarm_hit_flag(flag), .o_alarm_irq(irq),
    .o_month(month), .o_year(year), .o_feb_has_29(feb29));
  cal_host u_cal_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .i_rdata(rdata));

  // ****
  // helpers
  // ****
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    u_cal_host.get(a, rv);
    check(rv, exp);
  endtask : rchk

  // one-cycle pulse on tick, carry or clear; 3 raises tick and clear together
  task automatic pulse(input int which, input logic [6:0] s,
    input logic [6:0] m, input logic en);
    @(posedge clk);
    tick <= (which == 0) || (which == 3);
    carry <= (which == 1);
    clr <= (which >= 2);
    sec <= s;
    min <= m;
    irq_en <= en;
    @(posedge clk);
    tick <= 1'b0;
    carry <= 1'b0;
    clr <= 1'b0;
    #1;
  endtask : pulse

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_MONTH, 8'h01);
    rchk(OFS_YEAR, 8'h00);
    rchk(OFS_ALM_SEC, 8'h00);
    rchk(OFS_ALM_MIN, 8'h00);
    rchk(6'h0F, 8'h00);
    u_cal_host.put(6'h0F, 8'h85);
    rchk(6'h0F, 8'h00);
    rchk(OFS_ALM_SEC, 8'h00);
    u_cal_host.put(OFS_MONTH, 8'hF2);
    rchk(OFS_MONTH, 8'h12);
    u_cal_host.put(OFS_YEAR, 8'hF9);
    rchk(OFS_YEAR, 8'h79);
    pulse(1, 7'h00, 7'h00, 1'b0);
    check(month, 8'h01);
    check(year, 8'h00);
    @(posedge clk);
    #1;
    check({7'h00, feb29}, 8'h01);
    u_cal_host.put(OFS_MONTH, 8'h09);
    pulse(1, 7'h00, 7'h00, 1'b0);
    check(month, 8'h10);
    for (int i = 0; i < 8; i++)
    begin
      u_cal_host.put(OFS_YEAR, yrs[i]);
      @(posedge clk);
      #1;
      check({7'h00, feb29}, {7'h00, lp[i]});
    end
    // leap year seen while january steps into february
    u_cal_host.put(OFS_YEAR, 8'h24);
    u_cal_host.put(OFS_MONTH, 8'h01);
    pulse(1, 7'h00, 7'h00, 1'b0);
    check(month, 8'h02);
    check({7'h00, feb29}, 8'h01);
    // second alarm on 05, minute field disabled
    u_cal_host.put(OFS_ALM_SEC, 8'h85);
    rchk(OFS_ALM_SEC, 8'h85);
    u_cal_host.put(OFS_ALM_MIN, 8'h33);
    rchk(OFS_ALM_MIN, 8'h33);
    pulse(0, 7'h04, 7'h10, 1'b1);
    check({7'h00, flag}, 8'h00);
    pulse(0, 7'h05, 7'h10, 1'b1);
    check({6'h00, flag, irq}, 8'h03);
    pulse(2, 7'h05, 7'h10, 1'b1);
    pulse(0, 7'h05, 7'h10, 1'b1);
    check({6'h00, flag, irq}, 8'h00);
    pulse(0, 7'h06, 7'h10, 1'b1);
    pulse(0, 7'h05, 7'h10, 1'b0);
    check({7'h00, flag}, 8'h00);
    u_cal_host.put(OFS_ALM_MIN, 8'hB3);
    pulse(0, 7'h06, 7'h10, 1'b1);
    pulse(0, 7'h05, 7'h10, 1'b1);
    check({7'h00, flag}, 8'h00);
    pulse(0, 7'h05, 7'h33, 1'b1);
    check({6'h00, flag, irq}, 8'h03);
    pulse(2, 7'h05, 7'h33, 1'b1);
    check({6'h00, flag, irq}, 8'h00);
    u_cal_host.put(OFS_ALM_SEC, 8'h05);
    u_cal_host.put(OFS_ALM_MIN, 8'h33);
    pulse(0, 7'h06, 7'h10, 1'b1);
    pulse(0, 7'h05, 7'h33, 1'b1);
    check({7'h00, flag}, 8'h00);
    // first match and clear in one cycle: the set wins
    u_cal_host.put(OFS_ALM_SEC, 8'h85);
    pulse(0, 7'h06, 7'h33, 1'b1);
    pulse(3, 7'h05, 7'h33, 1'b1);
    check({6'h00, flag, irq}, 8'h03);
    // reset in mid-run brings flag, irq, month, year and second alarm back
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({6'h00, flag, irq}, 8'h00);
    rchk(OFS_MONTH, 8'h01);
    rchk(OFS_YEAR, 8'h00);
    rchk(OFS_ALM_SEC, 8'h00);
    tally_and_finish();
  end
endmodule : cal_alarm_tb

`default_nettype wire
